/* rtl/atp_top.sv */
// Threshold postprocessing: averaging filters, hysteresis comparators, duration counters
// Behaviour
// - Channel 9 result reads 10 bits, filtered or raw by its output-select bit.
// - Result register bits 31:10 read zero; writes do nothing.
// - Paths 0-5 and the channel 9 result offer a running average over 2, 4, 8 or 16 samples.
// - Filtered or raw value compared against per-channel upper and lower levels.
// - Upper and lower comparators each have their own programmable hysteresis.
// - Per-comparator counter integrates active output up to two to the exponent.
// - Upper counter stalls at its limit and raises the upper status.
// - Over-limit mode: lower counter counts while value is above lower level.
// - Rising edge of each upper or lower status can raise an interrupt.
// - Detection is delayed by two to the exponent samples of active comparator.
// - Upper enable bit n routes filter output of channel n; bits 7:6 read zero.
// - Registers are accessed as whole 32-bit words only.
// - Eight-bit levels for channels 0-9, four per word, two for channels 4-5.
// - Two-bit mode per channel 0-5: both, under only, over only, 11 reserved.
// - Lower enable bit n routes filter output of channel n into lower path.
`timescale 1ns/1ps
`include "atp_defines.svh"
module atp_top import atp_pkg::*; (
  input wire logic clk_sys, // 20 MHz system clock
  input wire logic reset, // Synchronous reset, active high
  input wire atp_sample_t sample, // Demultiplexed conversion result
  input wire logic [3:0] filtered_output_select_hi, // Output select, bit 3 for channel 9
  input wire logic [7:0] s_axi_awaddr, // Write address
  input wire logic s_axi_awvalid, // Write address valid
  output logic s_axi_awready, // Write address ready
  input wire logic [31:0] s_axi_wdata, // Write data
  input wire logic [3:0] s_axi_wstrb, // Write byte strobes
  input wire logic s_axi_wvalid, // Write data valid
  output logic s_axi_wready, // Write data ready
  output logic [1:0] s_axi_bresp, // Write response
  output logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic [7:0] s_axi_araddr, // Read address
  input wire logic s_axi_arvalid, // Read address valid
  output logic s_axi_arready, // Read address ready
  output logic [31:0] s_axi_rdata, // Read data
  output logic [1:0] s_axi_rresp, // Read response
  output logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready, // Read data ready
  output atp_flags_t path_status_flag, // Upper and lower status per channel
  output logic irq // Level interrupt
);
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  function automatic logic [7:0] atp_pick(input logic [31:0] w03, input logic [15:0] w45,
                                          input logic [31:0] w69, input logic [3:0] ch);
    logic [7:0] f;
    f = 8'h00;
    if (ch < 4'h4) begin
      f = w03[{ch[1:0], 3'b000} +: 8];
    end else if (ch < 4'h6) begin
      f = w45[{ch[0], 3'b000} +: 8];
    end else begin
      f = w69[{ch[1:0] + 2'h2, 3'b000} +: 8];
    end
    return f;
  endfunction : atp_pick

  // Register file
  logic [5:0] upf_ff, nxt_upf, lof_ff, nxt_lof;
  logic [31:0] lo_lvl03_ff, nxt_lo_lvl03, lo_lvl69_ff, nxt_lo_lvl69;
  logic [31:0] up_lvl03_ff, nxt_up_lvl03, up_lvl69_ff, nxt_up_lvl69;
  logic [31:0] lo_cnt03_ff, nxt_lo_cnt03, lo_cnt69_ff, nxt_lo_cnt69;
  logic [31:0] up_cnt03_ff, nxt_up_cnt03, up_cnt69_ff, nxt_up_cnt69;
  logic [15:0] lo_lvl45_ff, nxt_lo_lvl45, up_lvl45_ff, nxt_up_lvl45;
  logic [15:0] lo_cnt45_ff, nxt_lo_cnt45, up_cnt45_ff, nxt_up_cnt45;
  logic [11:0] mode_ff, nxt_mode;
  logic [19:0] depth_ff, nxt_depth, ist_ff, nxt_ist, imask_ff, nxt_imask;
  // Bus handshake
  logic aw_got_ff, nxt_aw_got, w_got_ff, nxt_w_got, bvalid_ff, nxt_bvalid;
  logic rvalid_ff, nxt_rvalid;
  logic [7:0] waddr_ff, nxt_waddr;
  logic [31:0] wdata_ff, nxt_wdata, rdata_ff, nxt_rdata;
  logic [3:0] wstrb_ff, nxt_wstrb;
  logic [1:0] bresp_ff, nxt_bresp, rresp_ff, nxt_rresp;
  // Datapath
  logic [13:0] acc_ff [10];
  logic [13:0] nxt_acc [10];
  logic [9:0] raw_ff [10];
  logic [9:0] nxt_raw [10];
  logic [15:0] cup_ff [10];
  logic [15:0] nxt_cup [10];
  logic [15:0] clo_ff [10];
  logic [15:0] nxt_clo [10];
  logic [9:0] aup_ff, nxt_aup, alo_ff, nxt_alo, sup_ff, nxt_sup, slo_ff, nxt_slo;
  logic pend_ff, nxt_pend;
  logic [3:0] pch_ff, nxt_pch;

  logic wr_fire;
  logic [19:0] ist_set;

  assign s_axi_awready = !aw_got_ff && !bvalid_ff;
  assign s_axi_wready = !w_got_ff && !bvalid_ff;
  assign s_axi_arready = !rvalid_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;
  assign path_status_flag = '{lower: slo_ff, upper: sup_ff};
  assign irq = |(ist_ff & imask_ff);
  assign wr_fire = aw_got_ff && w_got_ff && !bvalid_ff;

  // Bus slave: address and data may arrive in either order
  always_comb begin
    logic [31:0] rd;
    logic hit;
    logic [9:0] ch9;
    rd = 32'h0000_0000;
    hit = 1'b1;
    ch9 = filtered_output_select_hi[3] ? acc_ff[9][13:4] : raw_ff[9];
    nxt_aw_got = aw_got_ff;
    nxt_w_got = w_got_ff;
    nxt_waddr = waddr_ff;
    nxt_wdata = wdata_ff;
    nxt_wstrb = wstrb_ff;
    nxt_bvalid = bvalid_ff;
    nxt_bresp = bresp_ff;
    nxt_rvalid = rvalid_ff;
    nxt_rdata = rdata_ff;
    nxt_rresp = rresp_ff;
    if (s_axi_awvalid && s_axi_awready) begin
      nxt_aw_got = 1'b1;
      nxt_waddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      nxt_w_got = 1'b1;
      nxt_wdata = s_axi_wdata;
      nxt_wstrb = s_axi_wstrb;
    end
    if (wr_fire) begin
      nxt_aw_got = 1'b0;
      nxt_w_got = 1'b0;
      nxt_bvalid = 1'b1;
      nxt_bresp = (waddr_ff[1:0] == 2'b00 && waddr_ff >= `ATP_OFF_CH9_RESULT &&
                   waddr_ff <= `ATP_OFF_PATH_STATUS) ? RESP_OKAY : RESP_SLVERR;
    end
    if (bvalid_ff && s_axi_bready) begin
      nxt_bvalid = 1'b0;
    end
    unique case (s_axi_araddr)
      `ATP_OFF_CH9_RESULT: rd = {22'h000000, ch9};
      `ATP_OFF_UP_FILT_EN: rd = {26'h0000000, upf_ff};
      `ATP_OFF_LO_FILT_EN: rd = {26'h0000000, lof_ff};
      `ATP_OFF_LO_LVL_03: rd = lo_lvl03_ff;
      `ATP_OFF_LO_LVL_45: rd = {16'h0000, lo_lvl45_ff};
      `ATP_OFF_LO_LVL_69: rd = lo_lvl69_ff;
      `ATP_OFF_UP_LVL_03: rd = up_lvl03_ff;
      `ATP_OFF_UP_LVL_45: rd = {16'h0000, up_lvl45_ff};
      `ATP_OFF_UP_LVL_69: rd = up_lvl69_ff;
      `ATP_OFF_LO_CNT_03: rd = lo_cnt03_ff;
      `ATP_OFF_LO_CNT_45: rd = {16'h0000, lo_cnt45_ff};
      `ATP_OFF_LO_CNT_69: rd = lo_cnt69_ff;
      `ATP_OFF_UP_CNT_03: rd = up_cnt03_ff;
      `ATP_OFF_UP_CNT_45: rd = {16'h0000, up_cnt45_ff};
      `ATP_OFF_UP_CNT_69: rd = up_cnt69_ff;
      `ATP_OFF_MODE: rd = {20'h00000, mode_ff};
      `ATP_OFF_DEPTH: rd = {12'h000, depth_ff};
      `ATP_OFF_IRQ_STATUS: rd = {12'h000, ist_ff};
      `ATP_OFF_IRQ_MASK: rd = {12'h000, imask_ff};
      `ATP_OFF_PATH_STATUS: rd = {12'h000, slo_ff, sup_ff};
      default: hit = 1'b0;
    endcase
    if (s_axi_arvalid && s_axi_arready) begin
      nxt_rvalid = 1'b1;
      nxt_rdata = rd;
      nxt_rresp = hit ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_ff && s_axi_rready) begin
      nxt_rvalid = 1'b0;
    end
  end

  // Register writes; partial-word writes are dropped
  always_comb begin
    logic wr;
    wr = wr_fire && (wstrb_ff == 4'hF);
    nxt_upf = upf_ff;
    nxt_lof = lof_ff;
    nxt_lo_lvl03 = lo_lvl03_ff;
    nxt_lo_lvl45 = lo_lvl45_ff;
    nxt_lo_lvl69 = lo_lvl69_ff;
    nxt_up_lvl03 = up_lvl03_ff;
    nxt_up_lvl45 = up_lvl45_ff;
    nxt_up_lvl69 = up_lvl69_ff;
    nxt_lo_cnt03 = lo_cnt03_ff;
    nxt_lo_cnt45 = lo_cnt45_ff;
    nxt_lo_cnt69 = lo_cnt69_ff;
    nxt_up_cnt03 = up_cnt03_ff;
    nxt_up_cnt45 = up_cnt45_ff;
    nxt_up_cnt69 = up_cnt69_ff;
    nxt_mode = mode_ff;
    nxt_depth = depth_ff;
    nxt_imask = imask_ff;
    nxt_ist = ist_ff;
    if (wr) begin
      unique case (waddr_ff)
        `ATP_OFF_UP_FILT_EN: nxt_upf = wdata_ff[5:0];
        `ATP_OFF_LO_FILT_EN: nxt_lof = wdata_ff[5:0];
        `ATP_OFF_LO_LVL_03: nxt_lo_lvl03 = wdata_ff;
        `ATP_OFF_LO_LVL_45: nxt_lo_lvl45 = wdata_ff[15:0];
        `ATP_OFF_LO_LVL_69: nxt_lo_lvl69 = wdata_ff;
        `ATP_OFF_UP_LVL_03: nxt_up_lvl03 = wdata_ff;
        `ATP_OFF_UP_LVL_45: nxt_up_lvl45 = wdata_ff[15:0];
        `ATP_OFF_UP_LVL_69: nxt_up_lvl69 = wdata_ff;
        `ATP_OFF_LO_CNT_03: nxt_lo_cnt03 = wdata_ff;
        `ATP_OFF_LO_CNT_45: nxt_lo_cnt45 = wdata_ff[15:0];
        `ATP_OFF_LO_CNT_69: nxt_lo_cnt69 = wdata_ff;
        `ATP_OFF_UP_CNT_03: nxt_up_cnt03 = wdata_ff;
        `ATP_OFF_UP_CNT_45: nxt_up_cnt45 = wdata_ff[15:0];
        `ATP_OFF_UP_CNT_69: nxt_up_cnt69 = wdata_ff;
        `ATP_OFF_MODE: nxt_mode = wdata_ff[11:0];
        `ATP_OFF_DEPTH: nxt_depth = wdata_ff[19:0];
        `ATP_OFF_IRQ_MASK: nxt_imask = wdata_ff[19:0];
        `ATP_OFF_IRQ_STATUS: nxt_ist = ist_ff & ~wdata_ff[19:0];
        default: nxt_ist = ist_ff;
      endcase
    end
    nxt_ist = nxt_ist | ist_set; // Set wins over a same-cycle clear
  end

  // Stage 1 updates filter and raw copy; stage 2 compares and counts next cycle
  always_comb begin
    logic [3:0] c;
    logic [1:0] dep;
    logic signed [14:0] diff;
    logic [9:0] vu, vl;
    logic [7:0] vu8, vl8, lvu, lvl, cfu, cfl;
    logic [8:0] hu, hl;
    logic [15:0] lim_u, lim_l;
    logic mode_under, mode_over, act_u, act_l;
    c = pch_ff;
    dep = 2'b00;
    diff = 15'sh0000;
    nxt_acc = acc_ff;
    nxt_raw = raw_ff;
    nxt_cup = cup_ff;
    nxt_clo = clo_ff;
    nxt_aup = aup_ff;
    nxt_alo = alo_ff;
    nxt_sup = sup_ff;
    nxt_slo = slo_ff;
    nxt_pend = 1'b0;
    nxt_pch = pch_ff;
    if (sample.valid && sample.chan < 4'hA) begin
      dep = depth_ff[{sample.chan, 1'b0} +: 2];
      diff = $signed({1'b0, sample.data, 4'h0}) - $signed({1'b0, acc_ff[sample.chan]});
      // Running average over 2 to 16 samples, four fraction bits to limit drift
      // Shift widened so code 3 gives 4 and does not wrap to 0
      nxt_acc[sample.chan] = acc_ff[sample.chan] + 14'(diff >>> ({1'b0, dep} + 3'd1));
      nxt_raw[sample.chan] = sample.data;
      nxt_pend = 1'b1;
      nxt_pch = sample.chan;
    end
    vu = (c < 4'h6 && upf_ff[c[2:0]]) ? acc_ff[c][13:4] : raw_ff[c];
    vl = (c < 4'h6 && lof_ff[c[2:0]]) ? acc_ff[c][13:4] : raw_ff[c];
    vu8 = vu[9:2];
    vl8 = vl[9:2];
    lvu = atp_pick(up_lvl03_ff, up_lvl45_ff, up_lvl69_ff, c);
    lvl = atp_pick(lo_lvl03_ff, lo_lvl45_ff, lo_lvl69_ff, c);
    cfu = atp_pick(up_cnt03_ff, up_cnt45_ff, up_cnt69_ff, c);
    cfl = atp_pick(lo_cnt03_ff, lo_cnt45_ff, lo_cnt69_ff, c);
    hu = {5'h00, cfu[`ATP_CNT_HYST_LSB +: 4]};
    hl = {5'h00, cfl[`ATP_CNT_HYST_LSB +: 4]};
    lim_u = 16'h0001 << cfu[`ATP_CNT_EXP_LSB +: 4];
    lim_l = 16'h0001 << cfl[`ATP_CNT_EXP_LSB +: 4];
    mode_under = (c < 4'h6) && (mode_ff[{c[2:0], 1'b0} +: 2] == ATP_UNDER_LIMIT);
    mode_over = (c < 4'h6) && (mode_ff[{c[2:0], 1'b0} +: 2] == ATP_OVER_LIMIT);
    // Once active, a comparator holds until the value backs off by the hysteresis
    act_u = aup_ff[c] ? ({1'b0, vu8} + hu > {1'b0, lvu}) : (vu8 > lvu);
    act_u = act_u && !mode_under;
    if (mode_over) begin
      act_l = alo_ff[c] ? ({1'b0, vl8} + hl > {1'b0, lvl}) : (vl8 > lvl);
    end else begin
      act_l = alo_ff[c] ? ({1'b0, vl8} < {1'b0, lvl} + hl) : (vl8 < lvl);
    end
    if (pend_ff) begin
      nxt_aup[c] = act_u;
      nxt_alo[c] = act_l;
      if (!act_u) begin
        nxt_cup[c] = 16'h0000;
      end else if (cup_ff[c] < lim_u) begin
        nxt_cup[c] = cup_ff[c] + 16'h0001; // Stalls at the limit
      end
      if (!act_l) begin
        nxt_clo[c] = 16'h0000;
      end else if (clo_ff[c] < lim_l) begin
        nxt_clo[c] = clo_ff[c] + 16'h0001;
      end
      nxt_sup[c] = act_u && (nxt_cup[c] == lim_u);
      nxt_slo[c] = act_l && (nxt_clo[c] == lim_l);
    end
    ist_set = {nxt_slo & ~slo_ff, nxt_sup & ~sup_ff};
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      upf_ff <= `ATP_RST_FILT_EN;
      lof_ff <= `ATP_RST_FILT_EN;
      lo_lvl03_ff <= `ATP_RST_LO_LVL_03;
      lo_lvl45_ff <= `ATP_RST_LO_LVL_45;
      lo_lvl69_ff <= `ATP_RST_LO_LVL_69;
      up_lvl03_ff <= `ATP_RST_UP_LVL_03;
      up_lvl45_ff <= `ATP_RST_UP_LVL_45;
      up_lvl69_ff <= `ATP_RST_UP_LVL_69;
      lo_cnt03_ff <= `ATP_RST_LO_CNT_03;
      lo_cnt45_ff <= `ATP_RST_LO_CNT_45;
      lo_cnt69_ff <= `ATP_RST_LO_CNT_69;
      up_cnt03_ff <= `ATP_RST_UP_CNT_03;
      up_cnt45_ff <= `ATP_RST_UP_CNT_45;
      up_cnt69_ff <= `ATP_RST_UP_CNT_69;
      mode_ff <= `ATP_RST_MODE;
      depth_ff <= `ATP_RST_DEPTH;
      ist_ff <= 20'h00000;
      imask_ff <= 20'h00000;
      aw_got_ff <= 1'b0;
      w_got_ff <= 1'b0;
      waddr_ff <= 8'h00;
      wdata_ff <= 32'h0000_0000;
      wstrb_ff <= 4'h0;
      bvalid_ff <= 1'b0;
      bresp_ff <= RESP_OKAY;
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      rresp_ff <= RESP_OKAY;
      acc_ff <= '{default: 14'h0000};
      raw_ff <= '{default: 10'h000};
      cup_ff <= '{default: 16'h0000};
      clo_ff <= '{default: 16'h0000};
      aup_ff <= 10'h000;
      alo_ff <= 10'h000;
      sup_ff <= 10'h000;
      slo_ff <= 10'h000;
      pend_ff <= 1'b0;
      pch_ff <= 4'h0;
    end else begin
      upf_ff <= nxt_upf;
      lof_ff <= nxt_lof;
      lo_lvl03_ff <= nxt_lo_lvl03;
      lo_lvl45_ff <= nxt_lo_lvl45;
      lo_lvl69_ff <= nxt_lo_lvl69;
      up_lvl03_ff <= nxt_up_lvl03;
      up_lvl45_ff <= nxt_up_lvl45;
      up_lvl69_ff <= nxt_up_lvl69;
      lo_cnt03_ff <= nxt_lo_cnt03;
      lo_cnt45_ff <= nxt_lo_cnt45;
      lo_cnt69_ff <= nxt_lo_cnt69;
      up_cnt03_ff <= nxt_up_cnt03;
      up_cnt45_ff <= nxt_up_cnt45;
      up_cnt69_ff <= nxt_up_cnt69;
      mode_ff <= nxt_mode;
      depth_ff <= nxt_depth;
      ist_ff <= nxt_ist;
      imask_ff <= nxt_imask;
      aw_got_ff <= nxt_aw_got;
      w_got_ff <= nxt_w_got;
      waddr_ff <= nxt_waddr;
      wdata_ff <= nxt_wdata;
      wstrb_ff <= nxt_wstrb;
      bvalid_ff <= nxt_bvalid;
      bresp_ff <= nxt_bresp;
      rvalid_ff <= nxt_rvalid;
      rdata_ff <= nxt_rdata;
      rresp_ff <= nxt_rresp;
      acc_ff <= nxt_acc;
      raw_ff <= nxt_raw;
      cup_ff <= nxt_cup;
      clo_ff <= nxt_clo;
      aup_ff <= nxt_aup;
      alo_ff <= nxt_alo;
      sup_ff <= nxt_sup;
      slo_ff <= nxt_slo;
      pend_ff <= nxt_pend;
      pch_ff <= nxt_pch;
    end
  end
endmodule : atp_top

/* rtl/atp_defines.svh */
// Register offsets, field positions and reset values of the threshold postprocessing block
`ifndef ATP_DEFINES_SVH
`define ATP_DEFINES_SVH
`define ATP_OFF_CH9_RESULT 8'h74
`define ATP_OFF_UP_FILT_EN 8'h78
`define ATP_OFF_LO_FILT_EN 8'h7C
`define ATP_OFF_LO_LVL_03 8'h80
`define ATP_OFF_LO_LVL_45 8'h84
`define ATP_OFF_LO_LVL_69 8'h88
`define ATP_OFF_UP_LVL_03 8'h8C
`define ATP_OFF_UP_LVL_45 8'h90
`define ATP_OFF_UP_LVL_69 8'h94
`define ATP_OFF_LO_CNT_03 8'h98
`define ATP_OFF_LO_CNT_45 8'h9C
`define ATP_OFF_LO_CNT_69 8'hA0
`define ATP_OFF_UP_CNT_03 8'hA4
`define ATP_OFF_UP_CNT_45 8'hA8
`define ATP_OFF_UP_CNT_69 8'hAC
`define ATP_OFF_MODE 8'hB0
`define ATP_OFF_DEPTH 8'hB4
`define ATP_OFF_IRQ_STATUS 8'hB8
`define ATP_OFF_IRQ_MASK 8'hBC
`define ATP_OFF_PATH_STATUS 8'hC0
`define ATP_RST_FILT_EN 6'h3F
`define ATP_RST_LO_LVL_03 32'h3C2C3A42
`define ATP_RST_LO_LVL_45 16'h9A2C
`define ATP_RST_LO_LVL_69 32'hC7D3BBDB
`define ATP_RST_UP_LVL_03 32'hA8ABDAE2
`define ATP_RST_UP_LVL_45 16'hBC42
`define ATP_RST_UP_LVL_69 32'hE2FAC6EE
`define ATP_RST_LO_CNT_03 32'h12131312
`define ATP_RST_LO_CNT_45 16'h0A0A
`define ATP_RST_LO_CNT_69 32'h0A0A0A0A
`define ATP_RST_UP_CNT_03 32'h12131B1A
`define ATP_RST_UP_CNT_45 16'h1212
`define ATP_RST_UP_CNT_69 32'h1A1A1911
`define ATP_RST_MODE 12'h000
`define ATP_RST_DEPTH 20'hFFFFF
`define ATP_CNT_EXP_LSB 0
`define ATP_CNT_HYST_LSB 4
`define ATP_FILT_CHANS 6
`define ATP_FRAC_BITS 4
`endif

/* rtl/atp_pkg.sv */
// Types shared by the threshold postprocessing block
package atp_pkg;
  typedef struct packed {
    logic valid;
    logic [3:0] chan;
    logic [9:0] data;
  } atp_sample_t;
  typedef struct packed {
    logic [9:0] lower;
    logic [9:0] upper;
  } atp_flags_t;
  typedef enum logic [1:0] {
    ATP_BOTH_LIMITS = 2'b00,
    ATP_UNDER_LIMIT = 2'b01,
    ATP_OVER_LIMIT = 2'b10,
    ATP_MODE_RSVD = 2'b11
  } atp_mode_t;
endpackage : atp_pkg

/* tb/atp_adc_model.sv */
// Conversion result source standing in for the demultiplexer in front of the block
`timescale 1ns/1ps
module atp_adc_model import atp_pkg::*; (
  input wire logic clk_sys, // System clock
  input wire logic reset, // Synchronous reset, active high
  input wire logic go, // Request one result
  input wire logic [3:0] chan, // Channel of the result
  input wire logic [9:0] data, // Conversion value
  output atp_sample_t sample // One-cycle result pulse
);
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      sample <= '0;
    end else if (go) begin
      sample <= '{valid: 1'h1, chan: chan, data: data};
    end else begin
      // Stale payload inverted so nothing leans on a held bus
      sample <= '{valid: 1'h0, chan: ~sample.chan, data: ~sample.data};
    end
  end
endmodule : atp_adc_model

/* tb/atp_top_sva.sv */
// Port-level checker for the threshold postprocessing block
`timescale 1ns/1ps
module atp_top_sva import atp_pkg::*; (
  input wire logic clk_sys, // System clock
  input wire logic reset, // Synchronous reset
  input wire atp_sample_t sample, // Result stream
  input wire logic s_axi_awvalid, // Write address valid
  input wire logic s_axi_awready, // Write address ready
  input wire logic s_axi_wvalid, // Write data valid
  input wire logic s_axi_wready, // Write data ready
  input wire logic [1:0] s_axi_bresp, // Write response
  input wire logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic s_axi_arvalid, // Read address valid
  input wire logic s_axi_arready, // Read address ready
  input wire logic [31:0] s_axi_rdata, // Read data
  input wire logic [1:0] s_axi_rresp, // Read response
  input wire logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready, // Read data ready
  input wire atp_flags_t path_status_flag, // Status per path
  input wire logic irq // Level interrupt
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  property p_ar_answer; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  a_ar_answer: assert property (p_ar_answer) else $error("read not answered");
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read answer dropped");
  property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
  a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
  property p_b_answer;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:3] s_axi_bvalid;
  endproperty
  a_b_answer: assert property (p_b_answer) else $error("write not answered");
  property p_b_refuse; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
  a_b_refuse: assert property (p_b_refuse) else $error("write taken while answering");
  // Status moves only one edge after an accepted result
  property p_stat_cause; path_status_flag != $past(path_status_flag) |-> $past(sample.valid, 2); endproperty
  a_stat_cause: assert property (p_stat_cause) else $error("status moved without result");
  property p_stat_drop; sample.valid && sample.chan > 4'h9 |=> ##1 $stable(path_status_flag); endproperty
  a_stat_drop: assert property (p_stat_drop) else $error("bad channel changed status");
  property p_irq_cause;
    $rose(irq) |-> (path_status_flag & ~$past(path_status_flag)) != '0 ||
      $past(s_axi_wvalid && s_axi_wready, 2) || $past(s_axi_wvalid && s_axi_wready, 3);
  endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("interrupt without cause");
  property p_reset_vals;
    disable iff (1'h0) reset |=> s_axi_awready && s_axi_arready && !s_axi_bvalid &&
      !s_axi_rvalid && path_status_flag == '0 && !irq;
  endproperty
  a_reset_vals: assert property (p_reset_vals) else $error("outputs not idle after reset");
  c_irq: cover property ($rose(irq));
  c_upper: cover property ($rose(path_status_flag.upper[6]));
  c_lower: cover property ($rose(path_status_flag.lower[0]));
  c_slverr: cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
endmodule : atp_top_sva
bind atp_top atp_top_sva u_sva (.clk_sys, .reset, .sample, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .path_status_flag,
  .irq);

/* tb/testbench.sv */
// Self-checking bench: registers, channel 9 result, duration counters, modes
`timescale 1ns/1ps
module testbench import atp_pkg::*;;
  logic clk_sys = 1'h0;
  logic reset = 1'h1;
  logic go = 1'h0;
  logic [3:0] ch = 4'h0;
  logic [9:0] dat = 10'h000;
  logic [3:0] filtered_output_select_hi = 4'h0;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  atp_sample_t sample;
  atp_flags_t flags;
  int err_total = 0;
  int checks = 0;
  int cyc = 0;
  logic [31:0] rst_tab [15] = '{32'h3F, 32'h3F, 32'h3C2C3A42, 32'h9A2C, 32'hC7D3BBDB,
    32'hA8ABDAE2, 32'hBC42, 32'hE2FAC6EE, 32'h12131312, 32'h0A0A, 32'h0A0A0A0A,
    32'h12131B1A, 32'h1212, 32'h1A1A1911, 32'h0};
  logic [1:0] hi_tab [4] = '{2'h2, 2'h0, 2'h3, 2'h2};
  logic [1:0] lo_tab [4] = '{2'h1, 2'h1, 2'h0, 2'h1};
  atp_top dut (.clk_sys, .reset, .sample, .filtered_output_select_hi, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .path_status_flag(flags), .irq);
  atp_adc_model u_adc (.clk_sys, .reset, .go, .chan(ch), .data(dat), .sample);
  initial begin
    forever #25 clk_sys = ~clk_sys;
  end
  task automatic complete_run();
    $display("Checks %0d, mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : complete_run
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      err_total++;
      complete_run();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : check
  // Handshakes are taken at the rising edge; requests move only right after it
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    logic ta, tw, tk;
    @(posedge clk_sys);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    tk = 1'h0;
    while (!tk) begin
      @(posedge clk_sys);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      tk = s_axi_bvalid && s_axi_bready;
      if (tk) check(s_axi_bresp, 32'h0);
      if (ta) s_axi_awvalid <= 1'h0;
      if (tw) s_axi_wvalid <= 1'h0;
      if (tk) s_axi_bready <= 1'h0;
    end
    #1;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    logic ta, tr;
    logic [31:0] d;
    logic [1:0] r;
    @(posedge clk_sys);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    tr = 1'h0;
    while (!tr) begin
      @(posedge clk_sys);
      ta = s_axi_arvalid && s_axi_arready;
      tr = s_axi_rvalid && s_axi_rready;
      d = s_axi_rdata;
      r = s_axi_rresp;
      if (ta) s_axi_arvalid <= 1'h0;
      if (tr) s_axi_rready <= 1'h0;
    end
    check(d, e);
    check(r, er);
  endtask : rd
  // Result taken two edges after go; status lands one edge later
  task automatic send(input logic [3:0] c, input logic [9:0] v);
    @(posedge clk_sys);
    ch <= c;
    dat <= v;
    go <= 1'h1;
    @(posedge clk_sys);
    go <= 1'h0;
    repeat (2) @(posedge clk_sys);
    #1;
  endtask : send
  initial begin
    repeat (5) @(posedge clk_sys);
    reset <= 1'h0;
    for (int i = 0; i < 15; i++) begin
      rd(8'h78 + 8'(4 * i), rst_tab[i], 2'h0);
    end
    rd(8'hBC, 32'h0, 2'h0);
    rd(8'hB4, 32'hFFFFF, 2'h0);
    wr(8'h78, 32'hFFFFFFFF, 4'hF);
    rd(8'h78, 32'h3F, 2'h0);
    wr(8'h78, 32'h0, 4'h1);
    rd(8'h78, 32'h3F, 2'h0);
    wr(8'hB0, 32'hFFFFFFFF, 4'hF);
    rd(8'hB0, 32'hFFF, 2'h0);
    rd(8'hF0, 32'h0, 2'h2);
    rd(8'h79, 32'h0, 2'h2);
    $display("Test registers done");
    send(4'h9, 10'h2A5);
    rd(8'h74, 32'h2A5, 2'h0);
    wr(8'h74, 32'hFFFFFFFF, 4'hF);
    rd(8'h74, 32'h2A5, 2'h0);
    send(4'hA, 10'h3FF);
    rd(8'h74, 32'h2A5, 2'h0);
    // One sample into a 16-deep average from zero
    filtered_output_select_hi <= 4'h8;
    rd(8'h74, 32'h2A, 2'h0);
    $display("Test channel 9 result done");
    wr(8'h94, 32'hE2FAC680, 4'hF);
    wr(8'h88, 32'hC7D3BB10, 4'hF);
    wr(8'hAC, 32'h1A1A1902, 4'hF);
    wr(8'hBC, 32'h40, 4'hF);
    for (int i = 0; i < 5; i++) begin
      send(4'h6, 10'h3FC);
      check(flags.upper[6], i >= 3);
    end
    check(irq, 1'h1);
    rd(8'hB8, 32'h40, 2'h0);
    rd(8'hC0, 32'h40, 2'h0);
    send(4'h6, 10'h100);
    check(flags.upper[6], 1'h0);
    check(irq, 1'h1);
    wr(8'hB8, 32'h40, 4'hF);
    check(irq, 1'h0);
    wr(8'hBC, 32'h0, 4'hF);
    wr(8'hAC, 32'h1A1A1920, 4'hF);
    send(4'h6, 10'h3FC);
    check(irq, 1'h0);
    send(4'h6, 10'h1FC);
    check(flags.upper[6], 1'h1);
    send(4'h6, 10'h100);
    check(flags.upper[6], 1'h0);
    $display("Test duration counters done");
    wr(8'h78, 32'h0, 4'hF);
    wr(8'h7C, 32'h0, 4'hF);
    wr(8'h80, 32'h3C2C3A40, 4'hF);
    wr(8'h8C, 32'hA8ABDA80, 4'hF);
    wr(8'h98, 32'h12131300, 4'hF);
    wr(8'hA4, 32'h12131B00, 4'hF);
    for (int m = 0; m < 4; m++) begin
      wr(8'hB0, 32'(m), 4'hF);
      send(4'h0, 10'h3FC);
      check({flags.upper[0], flags.lower[0]}, hi_tab[m]);
      send(4'h0, 10'h004);
      check({flags.upper[0], flags.lower[0]}, lo_tab[m]);
    end
    wr(8'hB0, 32'h0, 4'hF);
    wr(8'h78, 32'h1, 4'hF);
    repeat (32) send(4'h0, 10'h000);
    send(4'h0, 10'h3FC);
    check(flags.upper[0], 1'h0);
    // Two-deep average on channel 0 follows the input quickly
    wr(8'hB4, 32'hFFFFC, 4'hF);
    repeat (2) send(4'h0, 10'h3FC);
    check(flags.upper[0], 1'h1);
    $display("Test modes and routing done");
    complete_run();
  end
endmodule : testbench
